// ### rtl/dnr_notice_core.sv
// Device notice scheduler and reservation element composer
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "dnr_defines.svh"

// How it works
// - Sleep notice is held back while a control transfer is unfinished.
// - Sleep notice: two header bytes, sleep type code, then one attribute byte.
// - Attribute bit 0 chooses sleep regardless or stay awake if work; rest zero.
// - At each granted notification slot one pending notice is sent: wake, else sleep, else alive.
// - Sleep resends end on a work element naming us, or after three tries.
// - Host wake notice: two header bytes followed by the wake type code.
// - Host wake resends end once a control message lacks the channel halt element.
// - A keepalive element listing our address starts alive notices.
// - Alive notice: two header bytes followed by the alive type code.
// - Software may substitute another notice type code for the alive code.
// - Keepalive-started alive notices end when our address is no longer listed.
// - Alive after leaving sleep ends after three sends or on endpoint traffic.
// - A reservation element is produced for each beacon requested while no element is being sent.
// - Reservation element byte 0 is the identifier 0x09.
// - Length byte equals four plus four times the allocation block count.
// - Control field: type 011B, priority bits 5:3, stream index bits 8:6.
// - Control field: reason 000B, status 1, owner 1, bits 15:14 zero.
// - Bytes 4 and 5 carry the broadcast cluster identifier.

module dnr_notice_core
(
	input  wire logic                    ref_clk_i,
	input  wire logic                    srst_i,
	input  wire logic [7:0]              reg_addr_i,
	input  wire logic [31:0]             reg_wdata_i,
	input  wire logic                    reg_wr_i,
	input  wire logic                    reg_rd_i,
	output logic [31:0]                  reg_rdata_o,
	input  wire logic                    slot_grant_i,
	input  wire logic                    ctrl_xfer_busy_i,
	input  wire logic                    work_addr_valid_i,
	input  wire logic [7:0]              work_addr_i,
	input  wire logic                    halt_elem_i,
	input  wire logic                    keepalive_addr_valid_i,
	input  wire logic [7:0]              keepalive_addr_i,
	input  wire logic                    mmc_end_i,
	input  wire logic                    fn_ep_txn_i,
	output dnr_pkg::dnr_notice_type      notice_o,
	input  wire logic                    beacon_req_i,
	output dnr_pkg::dnr_elem_type        elem_o
);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
		addr_hit = (a == off);
	endfunction

	wire logic wr_ctrl  = reg_wr_i && addr_hit(reg_addr_i, `DNR_OFF_CTRL);
	wire logic wr_ident = reg_wr_i && addr_hit(reg_addr_i, `DNR_OFF_IDENT);
	wire logic wr_rsv   = reg_wr_i && addr_hit(reg_addr_i, `DNR_OFF_RSV);

	wire logic sleep_go  = wr_ctrl && reg_wdata_i[`DNR_CTRL_SLEEP_GO];
	wire logic wake_go   = wr_ctrl && reg_wdata_i[`DNR_CTRL_WAKE_GO];
	wire logic resume_go = wr_ctrl && reg_wdata_i[`DNR_CTRL_RESUME];
	wire logic cancel    = wr_ctrl && reg_wdata_i[`DNR_CTRL_CANCEL];

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	logic        attr_q;
	logic        alt_en_q;
	logic [7:0]  dev_addr_q;
	logic [7:0]  alt_code_q;
	logic [15:0] header_q;
	logic [2:0]  stream_q;
	logic [2:0]  prio_q;
	logic [2:0]  nblk_q;
	logic [15:0] cluster_q;
	logic [31:0] alloc_q [`DNR_ALLOC_WORDS];

	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			attr_q   <= 1'h0;
			alt_en_q <= 1'h0;
		end
		else if (wr_ctrl)
		begin
			attr_q   <= reg_wdata_i[`DNR_CTRL_ATTR];
			alt_en_q <= reg_wdata_i[`DNR_CTRL_ALT_EN];
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			dev_addr_q <= 8'h00;
			alt_code_q <= 8'h00;
			header_q   <= 16'h0000;
		end
		else if (wr_ident)
		begin
			dev_addr_q <= reg_wdata_i[7:0];
			alt_code_q <= reg_wdata_i[15:8];
			header_q   <= reg_wdata_i[31:16];
		end
	end

	// Counts above the store size are held at the maximum
	wire logic [2:0] nblk_wr = (reg_wdata_i[10:8] > `DNR_ALLOC_MAX) ? `DNR_ALLOC_MAX
		: reg_wdata_i[10:8];

	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			stream_q  <= 3'h0;
			prio_q    <= 3'h0;
			nblk_q    <= 3'h0;
			cluster_q <= 16'h0000;
		end
		else if (wr_rsv)
		begin
			stream_q  <= reg_wdata_i[2:0];
			prio_q    <= reg_wdata_i[5:3];
			nblk_q    <= nblk_wr;
			cluster_q <= reg_wdata_i[31:16];
		end
	end

	genvar g;
	generate
		for (g = 0; g < `DNR_ALLOC_WORDS; g++)
		begin : g_alloc
			wire logic wr_alloc = reg_wr_i
				&& addr_hit(reg_addr_i, `DNR_OFF_ALLOC + 8'(g * 4));

			always_ff @(posedge ref_clk_i)
			begin
				if (srst_i)
					alloc_q[g] <= 32'h00000000;
				else if (wr_alloc)
					alloc_q[g] <= reg_wdata_i;
			end
		end
	endgenerate

	// ----------------------------------------
	// Host control message tracking
	// ----------------------------------------
	logic      halt_acc_q;
	logic      ka_acc_q;
	wire logic work_hit = work_addr_valid_i && (work_addr_i == dev_addr_q);
	wire logic ka_hit   = keepalive_addr_valid_i && (keepalive_addr_i == dev_addr_q);
	wire logic halt_now = halt_acc_q || halt_elem_i;
	wire logic ka_now   = ka_acc_q || ka_hit;

	// Flags gather one control message and restart at its end
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i || mmc_end_i)
		begin
			halt_acc_q <= 1'h0;
			ka_acc_q   <= 1'h0;
		end
		else
		begin
			halt_acc_q <= halt_now;
			ka_acc_q   <= ka_now;
		end
	end

	// ----------------------------------------
	// Slot arbitration
	// ----------------------------------------
	logic       sleep_pend_q;
	logic [1:0] sleep_try_q;
	logic       wake_pend_q;
	logic       ka_mode_q;
	logic       res_mode_q;
	logic [1:0] res_try_q;

	wire logic sleep_ok   = sleep_pend_q && !ctrl_xfer_busy_i;
	wire logic alive_pend = ka_mode_q || res_mode_q;

	// Wake outranks sleep so a wake attempt is never starved by sleep retries
	dnr_pkg::dnr_sel_type sel;

	assign sel = !slot_grant_i ? dnr_pkg::DNR_SEL_NONE
		: wake_pend_q ? dnr_pkg::DNR_SEL_WAKE
		: sleep_ok ? dnr_pkg::DNR_SEL_SLEEP
		: alive_pend ? dnr_pkg::DNR_SEL_ALIVE
		: dnr_pkg::DNR_SEL_NONE;

	wire logic sent_sleep = (sel == dnr_pkg::DNR_SEL_SLEEP);
	wire logic sent_alive = (sel == dnr_pkg::DNR_SEL_ALIVE);

	// ----------------------------------------
	// Sleep notice state
	// ----------------------------------------
	wire logic sleep_last = sent_sleep && (sleep_try_q == `DNR_TRY_LIMIT - 2'h1);

	// A fresh request wins over a cancel, a work hit or the last try in the same cycle; reset wins over it
	always_ff @(posedge ref_clk_i)
	begin
		if (sleep_go && !srst_i)
		begin
			sleep_pend_q <= 1'h1;
			sleep_try_q  <= 2'h0;
		end
		else if (srst_i || cancel || work_hit || sleep_last)
		begin
			sleep_pend_q <= 1'h0;
			sleep_try_q  <= 2'h0;
		end
		else if (sent_sleep)
			sleep_try_q <= sleep_try_q + 2'h1;
	end

	// ----------------------------------------
	// Host wake notice state
	// ----------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			wake_pend_q <= 1'h0;
		else if (wake_go)
			wake_pend_q <= 1'h1;
		else if (cancel || (mmc_end_i && !halt_now))
			wake_pend_q <= 1'h0;
	end

	// ----------------------------------------
	// Alive notice state
	// ----------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i || cancel)
			ka_mode_q <= 1'h0;
		else if (mmc_end_i)
			ka_mode_q <= ka_now;
	end

	wire logic res_last = sent_alive && res_mode_q
		&& (res_try_q == `DNR_TRY_LIMIT - 2'h1);

	always_ff @(posedge ref_clk_i)
	begin
		if (resume_go && !srst_i)
		begin
			res_mode_q <= 1'h1;
			res_try_q  <= 2'h0;
		end
		else if (srst_i || cancel || fn_ep_txn_i || res_last)
		begin
			res_mode_q <= 1'h0;
			res_try_q  <= 2'h0;
		end
		else if (sent_alive && res_mode_q)
			res_try_q <= res_try_q + 2'h1;
	end

	// ----------------------------------------
	// Notice frame build
	// ----------------------------------------
	wire logic [7:0] alive_code = alt_en_q ? alt_code_q : `DNR_TYPE_ALIVE;
	wire logic [7:0] attr_byte  = {7'h00, attr_q};
	dnr_pkg::dnr_notice_type notice_d;
	dnr_pkg::dnr_notice_type notice_q;

	always_comb
	begin
		notice_d       = '0;
		notice_d.bytes = {8'h00, 8'h00, header_q};
		case (sel)
			dnr_pkg::DNR_SEL_WAKE:
			begin
				notice_d.valid        = 1'h1;
				notice_d.len          = `DNR_LEN_SHORT;
				notice_d.bytes[23:16] = `DNR_TYPE_WAKE;
			end
			dnr_pkg::DNR_SEL_SLEEP:
			begin
				notice_d.valid        = 1'h1;
				notice_d.len          = `DNR_LEN_SLEEP;
				notice_d.bytes[23:16] = `DNR_TYPE_SLEEP;
				notice_d.bytes[31:24] = attr_byte;
			end
			dnr_pkg::DNR_SEL_ALIVE:
			begin
				notice_d.valid        = 1'h1;
				notice_d.len          = `DNR_LEN_SHORT;
				notice_d.bytes[23:16] = alive_code;
			end
			default:
				notice_d.valid = 1'h0;
		endcase
	end

	always_ff @(posedge ref_clk_i)
		notice_q <= srst_i ? '0 : notice_d;

	assign notice_o = notice_q;

	// ----------------------------------------
	// Reservation element stream
	// ----------------------------------------
	dnr_pkg::dnr_el_state_type el_state_q;
	logic [4:0]                el_idx_q;

	wire logic [15:0] rsv_ctrl = {`DNR_RSV_RESERVED, `DNR_RSV_OWNER, `DNR_RSV_STATUS,
		`DNR_RSV_REASON, stream_q, prio_q, `DNR_RSV_TYPE};
	wire logic [7:0]  elem_len = `DNR_ELEM_LEN_BASE + {3'h0, nblk_q, 2'h0};
	wire logic [4:0]  last_idx = `DNR_ELEM_HDR_LAST + {nblk_q, 2'h0};
	wire logic [4:0]  alloc_off = el_idx_q - `DNR_ELEM_ALLOC0;
	wire logic [7:0] alloc_byte = alloc_q[alloc_off[3:2]][8 * alloc_off[1:0] +: 8];
	wire logic [7:0]  el_byte = (el_idx_q == 5'h00) ? `DNR_ELEM_ID
		: (el_idx_q == 5'h01) ? elem_len
		: (el_idx_q == 5'h02) ? rsv_ctrl[7:0]
		: (el_idx_q == 5'h03) ? rsv_ctrl[15:8]
		: (el_idx_q == 5'h04) ? cluster_q[7:0]
		: (el_idx_q == 5'h05) ? cluster_q[15:8]
		: alloc_byte;
	dnr_pkg::dnr_elem_type elem_q;

	// One element per beacon; a request during a stream is ignored
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			el_state_q <= dnr_pkg::DNR_EL_IDLE;
			el_idx_q   <= 5'h00;
			elem_q     <= '0;
		end
		else
		begin
			case (el_state_q)
				dnr_pkg::DNR_EL_IDLE:
				begin
					elem_q <= '0;
					if (beacon_req_i)
					begin
						el_state_q <= dnr_pkg::DNR_EL_SEND;
						el_idx_q   <= 5'h00;
					end
				end
				dnr_pkg::DNR_EL_SEND:
				begin
					elem_q.valid <= 1'h1;
					elem_q.data  <= el_byte;
					elem_q.last  <= (el_idx_q == last_idx);
					el_idx_q     <= el_idx_q + 5'h01;
					if (el_idx_q == last_idx)
						el_state_q <= dnr_pkg::DNR_EL_IDLE;
				end
				default:
					el_state_q <= dnr_pkg::DNR_EL_IDLE;
			endcase
		end
	end

	assign elem_o = elem_q;

	// ----------------------------------------
	// Register read
	// ----------------------------------------
	logic [31:0]      rd_mux;
	logic [31:0]      rdata_q;
	wire logic [31:0] status_word = {23'h000000, el_state_q == dnr_pkg::DNR_EL_SEND, res_try_q,
		sleep_try_q, res_mode_q, ka_mode_q, wake_pend_q, sleep_pend_q};

	always_comb
	begin
		rd_mux = 32'h00000000;
		if (addr_hit(reg_addr_i, `DNR_OFF_CTRL))
			rd_mux = {27'h0000000, alt_en_q, 1'h0, attr_q, 2'h0};
		else if (addr_hit(reg_addr_i, `DNR_OFF_IDENT))
			rd_mux = {header_q, alt_code_q, dev_addr_q};
		else if (addr_hit(reg_addr_i, `DNR_OFF_RSV))
			rd_mux = {cluster_q, 5'h00, nblk_q, 2'h0, prio_q, stream_q};
		else if (addr_hit(reg_addr_i, `DNR_OFF_STATUS))
			rd_mux = status_word;
		else if (reg_addr_i[7:4] == 4'h1 && reg_addr_i[1:0] == 2'h0)
			rd_mux = alloc_q[reg_addr_i[3:2]];
	end

	// Read data stand for one cycle only, zero otherwise
	always_ff @(posedge ref_clk_i)
		rdata_q <= (reg_rd_i && !srst_i) ? rd_mux : 32'h00000000;

	assign reg_rdata_o = rdata_q;

endmodule // dnr_notice_core

// ### rtl/dnr_defines.svh
// Offsets, field positions, limits and codes of the device notice block
`ifndef DNR_DEFINES_SVH
`define DNR_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DNR_OFF_CTRL      8'h00
`define DNR_OFF_IDENT     8'h04
`define DNR_OFF_RSV       8'h08
`define DNR_OFF_STATUS    8'h0C
`define DNR_OFF_ALLOC     8'h10
`define DNR_ALLOC_WORDS   4
`define DNR_ALLOC_MAX     3'h4

// ----------------------------------------
// Control bits
// ----------------------------------------
`define DNR_CTRL_SLEEP_GO 0
`define DNR_CTRL_WAKE_GO  1
`define DNR_CTRL_ATTR     2
`define DNR_CTRL_RESUME   3
`define DNR_CTRL_ALT_EN   4
`define DNR_CTRL_CANCEL   5

// ----------------------------------------
// Notice type codes and layout
// ----------------------------------------
`define DNR_TYPE_SLEEP    8'h84
`define DNR_TYPE_WAKE     8'h85
`define DNR_TYPE_ALIVE    8'h86
`define DNR_LEN_SLEEP     3'h4
`define DNR_LEN_SHORT     3'h3
`define DNR_TRY_LIMIT     2'h3

// ----------------------------------------
// Reservation element constants
// ----------------------------------------
`define DNR_ELEM_ID       8'h09
`define DNR_ELEM_LEN_BASE 8'h04
`define DNR_RSV_TYPE      3'h3
`define DNR_RSV_REASON    3'h0
`define DNR_RSV_STATUS    1'h1
`define DNR_RSV_OWNER     1'h1
`define DNR_RSV_RESERVED  2'h0
`define DNR_ELEM_HDR_LAST 5'h05
`define DNR_ELEM_ALLOC0   5'h06

`endif

// ### rtl/dnr_pkg.sv
// Types shared by the device notice block and its users
package dnr_pkg;

	// ----------------------------------------
	// Outgoing notice frame, byte 0 in the low bits
	// ----------------------------------------
	typedef struct packed {
		logic        valid;
		logic [2:0]  len;
		logic [31:0] bytes;
	} dnr_notice_type;

	// ----------------------------------------
	// Reservation element byte stream
	// ----------------------------------------
	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] data;
	} dnr_elem_type;

	typedef enum logic [3:0] {
		DNR_SEL_NONE  = 4'b0001,
		DNR_SEL_WAKE  = 4'b0010,
		DNR_SEL_SLEEP = 4'b0100,
		DNR_SEL_ALIVE = 4'b1000
	} dnr_sel_type;

	typedef enum logic [1:0] {
		DNR_EL_IDLE = 2'b01,
		DNR_EL_SEND = 2'b10
	} dnr_el_state_type;

endpackage

// ### testbench/dnr_chk_props.sv
// Assertion checker for the device notice core
`timescale 1ns/1ps
`include "dnr_defines.svh"
module dnr_chk
(
	input wire logic                    ref_clk_i,
	input wire logic                    srst_i,
	input wire logic [7:0]              reg_addr_i,
	input wire logic [31:0]             reg_wdata_i,
	input wire logic                    reg_wr_i,
	input wire logic                    slot_grant_i,
	input wire logic                    ctrl_xfer_busy_i,
	input wire dnr_pkg::dnr_notice_type notice_o,
	input wire logic                    beacon_req_i,
	input wire dnr_pkg::dnr_elem_type   elem_o
);
// ----
// Helpers
// ----
default clocking cb @(posedge ref_clk_i); endclocking
default disable iff (srst_i);
logic [2:0] sc_q;
logic [4:0] bi_q;
logic [7:0] ln_q;
wire        sl  = notice_o.valid && notice_o.bytes[23:16] == `DNR_TYPE_SLEEP;
wire        arm = reg_wr_i && reg_addr_i == `DNR_OFF_CTRL && reg_wdata_i[0];
// Sleep sends since the last arming write
always_ff @(posedge ref_clk_i)
	if (srst_i || arm)
		sc_q <= 3'h0;
	else if (sl)
		sc_q <= sc_q + 3'h1;
// Byte index in the element and its length byte
always_ff @(posedge ref_clk_i)
begin
	bi_q <= elem_o.valid ? bi_q + 5'h1 : 5'h00;
	ln_q <= (elem_o.valid && bi_q == 5'h01) ? elem_o.data : ln_q;
end
// ----
// Properties
// ----
property p_grant;
	notice_o.valid |-> $past(slot_grant_i);
endproperty
a_grant: assert property (p_grant) else $error("notice without slot");
property p_busy;
	slot_grant_i && ctrl_xfer_busy_i |=> !sl;
endproperty
a_busy: assert property (p_busy) else $error("sleep sent while busy");
property p_slen;
	sl |-> notice_o.len == `DNR_LEN_SLEEP && notice_o.bytes[31:25] == 7'h00;
endproperty
a_slen: assert property (p_slen) else $error("sleep layout");
property p_olen;
	notice_o.valid && !sl |-> notice_o.len == `DNR_LEN_SHORT && notice_o.bytes[31:24] == 8'h00;
endproperty
a_olen: assert property (p_olen) else $error("short layout");
property p_tries;
	sl |-> sc_q < 3'h3;
endproperty
a_tries: assert property (p_tries) else $error("sleep beyond three");
property p_start;
	beacon_req_i && !elem_o.valid && !$past(beacon_req_i)
		|-> ##2 elem_o.valid && elem_o.data == 8'h09;
endproperty
a_start: assert property (p_start) else $error("element start");
property p_len;
	$rose(elem_o.valid) |=> elem_o.data[1:0] == 2'h0 && elem_o.data inside {[8'h04:8'h14]};
endproperty
a_len: assert property (p_len) else $error("length byte");
property p_ctrl;
	$rose(elem_o.valid) |-> ##2 elem_o.data[2:0] == 3'h3 ##1 elem_o.data[7:1] == 7'h18;
endproperty
a_ctrl: assert property (p_ctrl) else $error("control field");
property p_last;
	elem_o.last |-> elem_o.valid && bi_q == ln_q[4:0] + 5'h01 ##1 !elem_o.valid;
endproperty
a_last: assert property (p_last) else $error("element end");
endmodule // dnr_chk

bind dnr_notice_core dnr_chk dnr_chk_i (.ref_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i,
	.reg_wr_i, .slot_grant_i, .ctrl_xfer_busy_i, .notice_o, .beacon_req_i, .elem_o);

// ### testbench/dnr_host_model.sv
// Behavioural host: slot grants and control message elements
`timescale 1ns/1ps
module dnr_host_model
(
	input  wire logic ref_clk_i,
	output logic      slot_grant_o,
	output logic      work_vld_o,
	output logic [7:0] work_addr_o,
	output logic      halt_o,
	output logic      ka_vld_o,
	output logic [7:0] ka_addr_o,
	output logic      mmc_end_o,
	output logic      ep_txn_o
);
initial
begin
	{slot_grant_o, work_vld_o, halt_o, ka_vld_o, mmc_end_o, ep_txn_o} = 6'h00;
	work_addr_o = 8'h00;
	ka_addr_o = 8'h00;
end
// Slot after a prompt or slow gap
task automatic grant(input int gap);
	repeat (gap) @(posedge ref_clk_i);
	@(posedge ref_clk_i);
	slot_grant_o <= 1'b1;
	@(posedge ref_clk_i);
	slot_grant_o <= 1'b0;
endtask
// One control message; another device is always listed first
task automatic mmc(input logic halt, input logic ka, input logic [7:0] dev);
	@(posedge ref_clk_i);
	halt_o <= halt;
	ka_vld_o <= 1'b1;
	ka_addr_o <= dev ^ 8'h5A;
	@(posedge ref_clk_i);
	halt_o <= 1'b0;
	ka_vld_o <= ka;
	ka_addr_o <= dev;
	@(posedge ref_clk_i);
	ka_vld_o <= 1'b0;
	ka_addr_o <= ~dev;
	mmc_end_o <= 1'b1;
	@(posedge ref_clk_i);
	mmc_end_o <= 1'b0;
endtask
// Released address lines never keep the old value
task automatic work(input logic [7:0] a);
	@(posedge ref_clk_i);
	work_vld_o <= 1'b1;
	work_addr_o <= a;
	@(posedge ref_clk_i);
	work_vld_o <= 1'b0;
	work_addr_o <= ~a;
endtask
task automatic ep();
	@(posedge ref_clk_i);
	ep_txn_o <= 1'b1;
	@(posedge ref_clk_i);
	ep_txn_o <= 1'b0;
endtask
endmodule // dnr_host_model

// ### testbench/testbench.sv
// Self-checking bench for the device notice core
`timescale 1ns/1ps
`include "dnr_defines.svh"
module testbench;
logic clk, srst, wr, rd, busy, breq, attr;
logic [7:0] addr, dev, alt;
logic [31:0] wdata, rdata;
logic [15:0] hdr, cl;
logic [2:0] stm, pri;
logic [31:0] al [4];
logic [7:0] q [$];
wire grant, wv, halt, kv, mend, ept;
wire [7:0] wa, ka;
dnr_pkg::dnr_notice_type nt;
dnr_pkg::dnr_elem_type el;
int n_errors = 0;
int num_checks = 0;
int cyc = 0;
dnr_notice_core dnr_notice_core_i (.ref_clk_i(clk), .srst_i(srst), .reg_addr_i(addr),
	.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
	.slot_grant_i(grant), .ctrl_xfer_busy_i(busy), .work_addr_valid_i(wv), .work_addr_i(wa),
	.halt_elem_i(halt), .keepalive_addr_valid_i(kv), .keepalive_addr_i(ka), .mmc_end_i(mend),
	.fn_ep_txn_i(ept), .notice_o(nt), .beacon_req_i(breq), .elem_o(el));
dnr_host_model dnr_host_model_i (.ref_clk_i(clk), .slot_grant_o(grant), .work_vld_o(wv),
	.work_addr_o(wa), .halt_o(halt), .ka_vld_o(kv), .ka_addr_o(ka), .mmc_end_o(mend),
	.ep_txn_o(ept));
initial
begin
	clk = 1'b0;
	forever #5 clk = ~clk;
end
// Cuts a hang short
always @(posedge clk)
begin
	cyc++;
	if (cyc == 20000)
	begin
		n_errors++;
		close_out();
	end
end
task automatic close_out();
	$display("checks %0d errors %0d", num_checks, n_errors);
	if (n_errors == 0 && num_checks > 0)
		$display("DONE - PASS");
	else
		$display("DONE - FAIL");
	$finish;
endtask
task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
	num_checks++;
	if (g !== e)
	begin
		n_errors++;
		$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
	end
endtask
task automatic chk_notice(input dnr_pkg::dnr_notice_type e);
	num_checks++;
	if (nt !== e)
	begin
		n_errors++;
		$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, nt);
	end
endtask
function automatic dnr_pkg::dnr_notice_type exp_n(input logic [7:0] ty);
	exp_n.valid = 1'b1;
	exp_n.len = (ty == `DNR_TYPE_SLEEP) ? 3'h4 : 3'h3;
	exp_n.bytes = {(ty == `DNR_TYPE_SLEEP) ? {7'h00, attr} : 8'h00, ty, hdr};
endfunction
function automatic logic [7:0] exp_b(input int i, input int nb);
	logic [15:0] c;
	c = {2'h0, 1'b1, 1'b1, 3'h0, stm, pri, 3'h3};
	case (i)
		0: exp_b = 8'h09;
		1: exp_b = 8'(4 + 4 * nb);
		2: exp_b = c[7:0];
		3: exp_b = c[15:8];
		4: exp_b = cl[7:0];
		5: exp_b = cl[15:8];
		default: exp_b = al[(i - 6) / 4][8 * ((i - 6) % 4) +: 8];
	endcase
endfunction
task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
	@(posedge clk);
	addr <= a;
	wdata <= d;
	wr <= 1'b1;
	@(posedge clk);
	wr <= 1'b0;
endtask
task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
	@(posedge clk);
	addr <= a;
	rd <= 1'b1;
	@(posedge clk);
	rd <= 1'b0;
	#1;
	chk_word(e, rdata);
endtask
// A zero type means no notice is due
task automatic gr(input logic [7:0] ty);
	dnr_host_model_i.grant($urandom_range(3));
	#1;
	if (ty == 8'h00)
		chk_word(32'h0, {31'h0, nt.valid});
	else
		chk_notice(exp_n(ty));
endtask
// A second request lands mid-stream and must be ignored
task automatic beacon(input int nb);
	int k;
	q = {};
	@(posedge clk);
	breq <= 1'b1;
	for (k = 0; k < 40; k++)
	begin
		@(posedge clk);
		breq <= (k == 4);
		#1;
		if (el.valid === 1'b1)
			q.push_back(el.data);
		if (el.last === 1'b1)
			break;
	end
	chk_word(32'(6 + 4 * nb), 32'(q.size()));
	foreach (q[i])
		chk_word({24'h0, exp_b(i, nb)}, {24'h0, q[i]});
endtask
initial
begin
	{srst, wr, rd, busy, breq} = 5'h10;
	addr = 8'h00;
	wdata = 32'h0;
	void'($urandom(32'h1b888407));
	repeat (16) @(posedge clk);
	srst <= 1'b0;
	dev = 8'($urandom);
	hdr = 16'($urandom);
	attr = 1'($urandom);
	alt = {2'h1, 6'($urandom)};
	rd_chk(`DNR_OFF_STATUS, 32'h0);
	rd_chk(8'h20, 32'h0);
	wr_reg(`DNR_OFF_IDENT, {hdr, 8'h00, dev});
	wr_reg(`DNR_OFF_CTRL, {29'h0, attr, 2'h1});
	rd_chk(`DNR_OFF_CTRL, {29'h0, attr, 2'h0});
	rd_chk(`DNR_OFF_STATUS, 32'h1);
	@(posedge clk) busy <= 1'b1;
	gr(8'h00);
	@(posedge clk) busy <= 1'b0;
	gr(`DNR_TYPE_SLEEP);
	rd_chk(`DNR_OFF_STATUS, 32'h11);
	repeat (2) gr(`DNR_TYPE_SLEEP);
	gr(8'h00);
	wr_reg(`DNR_OFF_CTRL, {29'h0, attr, 2'h1});
	dnr_host_model_i.work(dev ^ 8'h01);
	gr(`DNR_TYPE_SLEEP);
	dnr_host_model_i.work(dev);
	gr(8'h00);
	wr_reg(`DNR_OFF_CTRL, {29'h0, attr, 2'h3});
	dnr_host_model_i.mmc(1'b1, 1'b0, dev);
	gr(`DNR_TYPE_WAKE);
	dnr_host_model_i.mmc(1'b0, 1'b0, dev);
	gr(`DNR_TYPE_SLEEP);
	dnr_host_model_i.work(dev);
	dnr_host_model_i.mmc(1'b0, 1'b1, dev);
	repeat (2) gr(`DNR_TYPE_ALIVE);
	wr_reg(`DNR_OFF_IDENT, {hdr, alt, dev});
	wr_reg(`DNR_OFF_CTRL, 32'h10);
	gr(alt);
	wr_reg(`DNR_OFF_CTRL, 32'h0);
	dnr_host_model_i.mmc(1'b0, 1'b0, dev);
	gr(8'h00);
	wr_reg(`DNR_OFF_CTRL, 32'h8);
	repeat (3) gr(`DNR_TYPE_ALIVE);
	gr(8'h00);
	wr_reg(`DNR_OFF_CTRL, 32'h8);
	gr(`DNR_TYPE_ALIVE);
	dnr_host_model_i.ep();
	gr(8'h00);
	wr_reg(`DNR_OFF_CTRL, 32'hB);
	wr_reg(`DNR_OFF_CTRL, 32'h20);
	gr(8'h00);
	rd_chk(`DNR_OFF_STATUS, 32'h0);
	for (int w = 0; w < 4; w++)
	begin
		al[w] = $urandom;
		wr_reg(8'(`DNR_OFF_ALLOC + 4 * w), al[w]);
	end
	// Count 7 is beyond the block limit and stores 4
	for (int n = 0; n < 6; n++)
	begin
		stm = 3'($urandom);
		pri = 3'($urandom);
		cl = 16'($urandom);
		wr_reg(`DNR_OFF_RSV, {cl, 5'h00, (n == 5) ? 3'h7 : 3'(n), 2'h0, pri, stm});
		beacon((n == 5) ? 4 : n);
	end
	close_out();
end
endmodule // testbench
